// File: common/ptcr_pkg.sv
// Constants shared by the transceiver tuning register bank.
package ptcr_pkg;

  localparam int PTCR_NREG = 9;
  localparam int PTCR_ADDR_W = 12;
  localparam int PTCR_DATA_W = 32;
  localparam int PTCR_REG_W = 16;

  // Register indices as printed; the APB byte address is four times the index.
  localparam logic [9:0] PTCR_IDX_SWING_CD = 10'h0a3;
  localparam logic [9:0] PTCR_IDX_RX_LPF = 10'h0b3;
  localparam logic [9:0] PTCR_IDX_RX_EQ_EN = 10'h0c0;
  localparam logic [9:0] PTCR_IDX_CLK_SEL = 10'h0c6;
  localparam logic [9:0] PTCR_IDX_MAC_CTRL = 10'h0d3;
  localparam logic [9:0] PTCR_IDX_SYNC_BUF = 10'h0e9;
  localparam logic [9:0] PTCR_IDX_LOOPBACK = 10'h0fe;
  localparam logic [9:0] PTCR_IDX_DSP = 10'h100;
  localparam logic [9:0] PTCR_IDX_FFE = 10'h12c;

  // Storage slots inside the bank.
  localparam int PTCR_S_SWING = 0;
  localparam int PTCR_S_LPF = 1;
  localparam int PTCR_S_EQ = 2;
  localparam int PTCR_S_CLK = 3;
  localparam int PTCR_S_MAC = 4;
  localparam int PTCR_S_SYNC = 5;
  localparam int PTCR_S_LOOP = 6;
  localparam int PTCR_S_DSP = 7;
  localparam int PTCR_S_FFE = 8;

  // Field positions.
  localparam int PTCR_SWD_OVR_BIT = 13;
  localparam int PTCR_SWD_MSB = 12;
  localparam int PTCR_SWD_LSB = 8;
  localparam int PTCR_SWC_OVR_BIT = 5;
  localparam int PTCR_SWC_MSB = 4;
  localparam int PTCR_SWC_LSB = 0;
  localparam int PTCR_CLKSEL_BIT = 4;
  localparam int PTCR_MACTYPE_BIT = 14;
  localparam int PTCR_FFE_MSB = 9;

  localparam logic [9:0] PTCR_IDX_TABLE [PTCR_NREG] = '{
    PTCR_IDX_SWING_CD, PTCR_IDX_RX_LPF, PTCR_IDX_RX_EQ_EN, PTCR_IDX_CLK_SEL,
    PTCR_IDX_MAC_CTRL, PTCR_IDX_SYNC_BUF, PTCR_IDX_LOOPBACK, PTCR_IDX_DSP, PTCR_IDX_FFE};
  localparam logic [15:0] PTCR_RW_MASK [PTCR_NREG] = '{
    16'h3f3f, 16'hffff, 16'hffff, 16'h0010, 16'h4000, 16'hffff, 16'hffff, 16'hffff, 16'h03ff};
  localparam logic [15:0] PTCR_RST_VAL [PTCR_NREG] = '{
    16'h1010, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h9f22, 16'he721, 16'h0000, 16'h0000};
  // Read-only bits that always read as a fixed pattern.
  localparam logic [15:0] PTCR_RO_FIXED [PTCR_NREG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0c00};

endpackage

// File: hw/ptcr_regs.sv
// APB register bank for line-driver swing, receiver, clock-out and MAC interface tuning.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps

module ptcr_regs
  import ptcr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [PTCR_ADDR_W-1:0] i_paddr,
  input wire logic [PTCR_DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [PTCR_DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  input wire logic [4:0] i_internal_swing_chan_c,
  input wire logic [4:0] i_internal_swing_chan_d,
  output logic [4:0] o_swing_chan_c,
  output logic [4:0] o_swing_chan_d,
  input wire logic i_normal_clk_out,
  input wire logic i_internal_transmit_clock,
  output logic o_clk_out,
  output logic o_serial_mac_6wire,
  output logic o_mac_diff_clk_en,
  output logic [15:0] o_rx_lowpass_word,
  output logic [15:0] o_rx_equalizer_enable_word,
  output logic [15:0] o_sync_buffer_word,
  output logic [15:0] o_loopback_setup_value,
  output logic [15:0] o_signal_processing_word,
  output logic [9:0] o_feedforward_equalizer_field,
  input wire logic i_soft_reset,
  output logic o_loopback_reset_pending
);

  logic [15:0] regs_q [PTCR_NREG];
  logic [PTCR_NREG-1:0] hit;
  logic [15:0] rd_chain [PTCR_NREG+1];
  logic [PTCR_DATA_W-1:0] prdata_q;
  logic slverr_q;
  logic [4:0] swing_c_q;
  logic [4:0] swing_d_q;
  logic clk_out_q;
  logic mac6_q;
  logic pend_q;

  wire setup_phase = i_psel & ~i_penable;
  wire access_phase = i_psel & i_penable;
  wire wr_en = access_phase & i_pwrite;
  wire mapped = |hit;
  wire [15:0] lane_mask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  wire loop_write = wr_en & hit[PTCR_S_LOOP];

  wire [15:0] swing_word = regs_q[PTCR_S_SWING];
  wire ovr_d = swing_word[PTCR_SWD_OVR_BIT];
  wire ovr_c = swing_word[PTCR_SWC_OVR_BIT];
  wire [4:0] val_d = swing_word[PTCR_SWD_MSB:PTCR_SWD_LSB];
  wire [4:0] val_c = swing_word[PTCR_SWC_MSB:PTCR_SWC_LSB];
  wire clk_sel = regs_q[PTCR_S_CLK][PTCR_CLKSEL_BIT];
  wire mac_type = regs_q[PTCR_S_MAC][PTCR_MACTYPE_BIT];

  // The bank answers every access with no wait state.
  assign o_pready = 1'b1;

  assign rd_chain[0] = 16'h0000;

  genvar g;
  generate
    for (g = 0; g < PTCR_NREG; g++)
    begin : g_reg
      wire [15:0] wmask = PTCR_RW_MASK[g] & lane_mask;
      // Reserved bits are never stored, so they read zero except the fixed bits in PTCR_RO_FIXED (FFE bits 11:10 read one).
      wire [15:0] rd_word = (regs_q[g] & PTCR_RW_MASK[g]) | PTCR_RO_FIXED[g];

      assign hit[g] = (i_paddr == {PTCR_IDX_TABLE[g], 2'b00});
      assign rd_chain[g+1] = rd_chain[g] | (hit[g] ? rd_word : 16'h0000);

      always_ff @(posedge i_sys_clk)
      begin
        if (i_rst)
          regs_q[g] <= PTCR_RST_VAL[g];
        else if (wr_en && hit[g])
          regs_q[g] <= (regs_q[g] & ~wmask) | (i_pwdata[15:0] & wmask);
      end
    end
  endgenerate

  // Read data is latched in the setup cycle so it comes from a flop during the access cycle.
  // Whole word read.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_q <= {16'h0000, rd_chain[PTCR_NREG]};
      slverr_q <= ~mapped;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pslverr = slverr_q;

  wire [4:0] swing_d_d = ovr_d ? val_d : i_internal_swing_chan_d;
  wire [4:0] swing_c_d = ovr_c ? val_c : i_internal_swing_chan_c;
  wire clk_out_d = clk_sel ? i_internal_transmit_clock : i_normal_clk_out;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      swing_d_q <= 5'h00;
    else
      swing_d_q <= swing_d_d;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      swing_c_q <= 5'h00;
    else
      swing_c_q <= swing_c_d;
  end

  // The clock inputs are sampled on the system clock, so the routed clock is only
  // a faithful copy while it runs well below half the system rate.
  // Routed clock register.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      clk_out_q <= 1'b0;
    else
      clk_out_q <= clk_out_d;
  end

  // Wire mode follows the type bit.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      mac6_q <= 1'b0;
    else
      mac6_q <= mac_type;
  end

  // Flag a loopback change until the host's soft reset; a new change wins.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      pend_q <= 1'b0;
    else if (loop_write)
      pend_q <= 1'b1;
    else if (i_soft_reset)
      pend_q <= 1'b0;
  end

  assign o_swing_chan_d = swing_d_q;
  assign o_swing_chan_c = swing_c_q;
  assign o_clk_out = clk_out_q;
  assign o_serial_mac_6wire = mac6_q;
  assign o_mac_diff_clk_en = mac6_q;
  assign o_rx_lowpass_word = regs_q[PTCR_S_LPF];
  assign o_rx_equalizer_enable_word = regs_q[PTCR_S_EQ];
  // Sync buffer word is plain storage.
  assign o_sync_buffer_word = regs_q[PTCR_S_SYNC];
  assign o_loopback_setup_value = regs_q[PTCR_S_LOOP];
  assign o_signal_processing_word = regs_q[PTCR_S_DSP];
  assign o_feedforward_equalizer_field = regs_q[PTCR_S_FFE][PTCR_FFE_MSB:0];
  assign o_loopback_reset_pending = pend_q;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  swing_d_sel_a: assert property (
    !$past(i_rst) |-> o_swing_chan_d ==
      ($past(regs_q[PTCR_S_SWING][PTCR_SWD_OVR_BIT]) ?
       $past(regs_q[PTCR_S_SWING][PTCR_SWD_MSB:PTCR_SWD_LSB]) :
       $past(i_internal_swing_chan_d)))
    else $error("channel D swing does not follow override");

  swing_c_sel_a: assert property (
    !$past(i_rst) |-> o_swing_chan_c ==
      ($past(regs_q[PTCR_S_SWING][PTCR_SWC_OVR_BIT]) ?
       $past(regs_q[PTCR_S_SWING][PTCR_SWC_MSB:PTCR_SWC_LSB]) :
       $past(i_internal_swing_chan_c)))
    else $error("channel C swing does not follow override");

  clk_rsvd_zero_a: assert property (
    (setup_phase && hit[PTCR_S_CLK]) |=> (o_prdata & 32'hffff_ffef) == 32'h0000_0000)
    else $error("clock-out reserved bits read non-zero");

  mac_rsvd_zero_a: assert property (
    (setup_phase && hit[PTCR_S_MAC]) |=> (o_prdata & 32'hffff_bfff) == 32'h0000_0000)
    else $error("MAC interface reserved bits read non-zero");

  clk_out_mux_a: assert property (
    (regs_q[PTCR_S_CLK][PTCR_CLKSEL_BIT] && $stable(regs_q[PTCR_S_CLK]))
      |=> o_clk_out == $past(i_internal_transmit_clock))
    else $error("clock output not taken from transmit clock");

  mac_mode_a: assert property (
    wr_en && hit[PTCR_S_MAC] && i_pstrb[1]
      |=> ##1 o_serial_mac_6wire == $past(i_pwdata[PTCR_MACTYPE_BIT], 2)
              && o_mac_diff_clk_en == o_serial_mac_6wire)
    else $error("MAC wire mode does not follow type bit");

  sync_reset_val_a: assert property (
    $past(i_rst) |-> o_sync_buffer_word == 16'h9f22)
    else $error("sync buffer word has wrong reset value");

  swing_write_a: assert property (
    wr_en && hit[PTCR_S_SWING] && (i_pstrb[1:0] == 2'b11)
      |=> regs_q[PTCR_S_SWING] == ($past(i_pwdata[15:0]) & 16'h3f3f))
    else $error("swing register write not masked to writable bits");

  read_width_a: assert property (
    (setup_phase && hit[PTCR_S_LOOP])
      |=> o_prdata == {16'h0000, $past(regs_q[PTCR_S_LOOP])} && !o_pslverr)
    else $error("loopback word not returned whole");

  unmapped_err_a: assert property (
    (setup_phase && !mapped)
      |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped address not answered with an error");

  mapped_ok_a: assert property (
    (setup_phase && mapped)
      |=> !o_pslverr)
    else $error("mapped address answered with an error");

  prdata_hold_a: assert property (
    !setup_phase
      |=> $stable(o_prdata) && $stable(o_pslverr))
    else $error("read data changed outside a setup cycle");

  swing_rsvd_zero_a: assert property (
    (setup_phase && hit[PTCR_S_SWING])
      |=> (o_prdata & 32'hffff_c0c0) == 32'h0000_0000)
    else $error("swing register reserved bits read non-zero");

  ffe_fixed_a: assert property (
    (setup_phase && hit[PTCR_S_FFE])
      |=> o_prdata[15:10] == 6'h03)
    else $error("equalizer register fixed bits read wrong");

  clk_write_a: assert property (
    (wr_en && hit[PTCR_S_CLK] && i_pstrb[0])
      |=> regs_q[PTCR_S_CLK] == ($past(i_pwdata[15:0]) & 16'h0010))
    else $error("clock-out register kept a reserved bit");

  mac_write_a: assert property (
    (wr_en && hit[PTCR_S_MAC] && i_pstrb[1])
      |=> regs_q[PTCR_S_MAC] == ($past(i_pwdata[15:0]) & 16'h4000))
    else $error("MAC interface register kept a reserved bit");

  clk_normal_a: assert property (
    !regs_q[PTCR_S_CLK][PTCR_CLKSEL_BIT]
      |=> o_clk_out == $past(i_normal_clk_out))
    else $error("clock output not taken from normal clock");

  pend_set_a: assert property (
    loop_write
      |=> o_loopback_reset_pending)
    else $error("loopback change not flagged");

  pend_clear_a: assert property (
    (i_soft_reset && !loop_write)
      |=> !o_loopback_reset_pending)
    else $error("pending flag not cleared by soft reset");

  pend_hold_a: assert property (
    (!loop_write && !i_soft_reset)
      |=> $stable(o_loopback_reset_pending))
    else $error("pending flag changed with no cause");

  lowpass_write_a: assert property (
    (wr_en && hit[PTCR_S_LPF] && i_pstrb[1:0] == 2'b11)
      |=> o_rx_lowpass_word == $past(i_pwdata[15:0]))
    else $error("receiver low-pass word not written whole");

  eq_write_a: assert property (
    (wr_en && hit[PTCR_S_EQ] && i_pstrb[1:0] == 2'b11)
      |=> o_rx_equalizer_enable_word == $past(i_pwdata[15:0]))
    else $error("receiver equalizer word not written whole");

  dsp_write_a: assert property (
    (wr_en && hit[PTCR_S_DSP] && i_pstrb[1:0] == 2'b11)
      |=> o_signal_processing_word == $past(i_pwdata[15:0]))
    else $error("signal-processing word not written whole");

  loop_write_a: assert property (
    (wr_en && hit[PTCR_S_LOOP] && i_pstrb[1:0] == 2'b11)
      |=> o_loopback_setup_value == $past(i_pwdata[15:0]))
    else $error("loopback word not written whole");

  sync_write_a: assert property (
    (wr_en && hit[PTCR_S_SYNC] && i_pstrb[1:0] == 2'b11)
      |=> o_sync_buffer_word == $past(i_pwdata[15:0]))
    else $error("sync buffer word not written whole");

  ffe_write_a: assert property (
    (wr_en && hit[PTCR_S_FFE] && i_pstrb[1:0] == 2'b11)
      |=> o_feedforward_equalizer_field == $past(i_pwdata[9:0]))
    else $error("equalizer field not written");

  swing_reset_a: assert property (
    $past(i_rst)
      |-> regs_q[PTCR_S_SWING] == 16'h1010
          && o_swing_chan_d == 5'h00 && o_swing_chan_c == 5'h00)
    else $error("swing register or outputs wrong after reset");

  loop_reset_a: assert property (
    $past(i_rst)
      |-> o_loopback_setup_value == 16'he721 && !o_loopback_reset_pending)
    else $error("loopback word or pending flag wrong after reset");

  mode_reset_a: assert property (
    $past(i_rst)
      |-> !o_serial_mac_6wire && !o_mac_diff_clk_en && !o_clk_out)
    else $error("wire mode or clock output wrong after reset");

endmodule

// File: testbench/tb_ptcr_regs.sv
// Self-checking bench for the tuning register bank.
`timescale 1ns/1ps
module tb_ptcr_regs;
  import ptcr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, srst = 1'b0;
  logic nclk = 1'b0, tclk = 1'b1, prdy, perr, clko, m6, mdc, pend;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [4:0] isc = 5'h03, isd = 5'h07, osc, osd;
  logic [15:0] lpf, eq, syn, lpb, dsp;
  logic [9:0] ffe;
  logic err;
  int fails = 0, samples_checked = 0, cyc = 0;
  always #25 clk = ~clk;
  ptcr_regs i_ptcr_regs (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(prdy),
    .o_prdata(prdata), .o_pslverr(perr), .i_internal_swing_chan_c(isc),
    .i_internal_swing_chan_d(isd), .o_swing_chan_c(osc), .o_swing_chan_d(osd),
    .i_normal_clk_out(nclk), .i_internal_transmit_clock(tclk), .o_clk_out(clko),
    .o_serial_mac_6wire(m6), .o_mac_diff_clk_en(mdc), .o_rx_lowpass_word(lpf),
    .o_rx_equalizer_enable_word(eq), .o_sync_buffer_word(syn), .o_loopback_setup_value(lpb),
    .o_signal_processing_word(dsp), .o_feedforward_equalizer_field(ffe),
    .i_soft_reset(srst), .o_loopback_reset_pending(pend));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_bank();
    for (int i = 0; i < PTCR_NREG; i++)
    begin
      apb(1'b0, PTCR_IDX_TABLE[i], 16'h0000);
      chk(rd, {16'h0000, PTCR_RST_VAL[i] | PTCR_RO_FIXED[i]}, "reset value");
      chk({31'h0000_0000, err}, 32'h0000_0000, "mapped access error");
    end
    for (int i = 0; i < PTCR_NREG; i++)
    begin
      apb(1'b1, PTCR_IDX_TABLE[i], 16'hffff);
      apb(1'b0, PTCR_IDX_TABLE[i], 16'h0000);
      chk(rd, {16'h0000, PTCR_RW_MASK[i] | PTCR_RO_FIXED[i]}, "masked write");
    end
    apb(1'b0, 10'h001, 16'h0000);
    chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
    $display("test bank done");
  endtask
  task automatic t_swing();
    apb(1'b1, PTCR_IDX_SWING_CD, 16'h0000);
    repeat (2) @(posedge clk);
    chk({22'h00_0000, osd, osc}, {22'h00_0000, 5'h07, 5'h03}, "internal swing");
    apb(1'b1, PTCR_IDX_SWING_CD, 16'h2a15);
    repeat (2) @(posedge clk);
    chk({22'h00_0000, osd, osc}, {22'h00_0000, 5'h0a, 5'h03}, "d forced");
    apb(1'b1, PTCR_IDX_SWING_CD, 16'h0a35);
    repeat (2) @(posedge clk);
    chk({22'h00_0000, osd, osc}, {22'h00_0000, 5'h07, 5'h15}, "c forced");
    $display("test swing done");
  endtask
  task automatic t_modes();
    apb(1'b1, PTCR_IDX_CLK_SEL, 16'h0000);
    apb(1'b1, PTCR_IDX_MAC_CTRL, 16'hbfff);
    repeat (2) @(posedge clk);
    chk({29'h0000_0000, clko, m6, mdc}, 32'h0000_0000, "normal clock, 4-wire");
    apb(1'b1, PTCR_IDX_CLK_SEL, 16'hfff0);
    apb(1'b1, PTCR_IDX_MAC_CTRL, 16'h4000);
    repeat (2) @(posedge clk);
    chk({29'h0000_0000, clko, m6, mdc}, 32'h0000_0007, "tx clock, 6-wire");
    apb(1'b0, PTCR_IDX_CLK_SEL, 16'h0000);
    chk(rd, 32'h0000_0010, "clock select readback");
    $display("test modes done");
  endtask
  task automatic t_words();
    apb(1'b1, PTCR_IDX_RX_LPF, 16'h000c);
    apb(1'b1, PTCR_IDX_RX_EQ_EN, 16'h0000);
    apb(1'b1, PTCR_IDX_DSP, 16'h1027);
    apb(1'b1, PTCR_IDX_FFE, 16'h0e81);
    apb(1'b1, PTCR_IDX_SYNC_BUF, 16'h1234);
    apb(1'b0, PTCR_IDX_FFE, 16'h0000);
    chk(rd, 32'h0000_0e81, "ffe readback");
    chk({lpf, eq}, 32'h000c_0000, "receiver words");
    chk({dsp, 6'h00, ffe}, 32'h1027_0281, "dsp and equalizer words");
    chk({16'h0000, syn}, 32'h0000_1234, "sync word");
    $display("test words done");
  endtask
  task automatic t_loop();
    apb(1'b1, PTCR_IDX_LOOPBACK, 16'he721);
    chk({lpb, 15'h0000, pend}, 32'he721_0001, "loopback pending");
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, pend}, 32'h0, "pending cleared");
    $display("test loop done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_bank();
    t_swing();
    t_modes();
    t_words();
    t_loop();
    summarize();
  end
endmodule
